// file: dp_ram_port.sv
// One port of the synchronous dual-port RAM with burst counter
// Operation
// - Strobe low at edge loads counter from the address and uses it.
// - Selected only when low-active select low and high-active high.
// - Works with free-running or gated clock; state only moves on edges.
// - Advance low increments counter on every rising edge.
// - Advance ignored while strobe or clear is low.
// - Clear low at an edge sets counter to zero.
// - Clear wins over strobe and advance.
// - Lower byte written or driven only while its select is low.
// - Lower byte driven on read only with its select and output enable.
// - Upper byte select gates upper bits the same way.
// - Data pins undriven unless output enable is low.
// - Read/write low writes, high reads, at the sampling edge.
// - Mode low gives flow-through data, high adds output register.
// - Counter wraps from last location to zero.
// - Output enable sampled on the edge like the others; no combinational path.
// - Strobe high takes access address from the counter.
`timescale 1ns/100ps
`default_nettype none
module dp_ram_port
    import dp_ram_pkg::*;
#(
    parameter int ADDR_W = dp_ram_pkg::ADDR_W_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Address and burst counter control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic burst_clear_n,
    // Selects and direction
    input wire logic port_sel_low_n,
    input wire logic port_sel_high,
    input wire logic rd_wr_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    input wire logic out_en_n,
    input wire logic output_register_sel,
    // Data pins
    input wire logic [dp_ram_pkg::DATA_W-1:0] data_in,
    output logic [dp_ram_pkg::DATA_W-1:0] data_out,
    output logic [dp_ram_pkg::DATA_W-1:0] data_oe_n,
    // Second port of the shared array
    input wire logic [ADDR_W-1:0] b_addr,
    input wire logic b_wr_lo,
    input wire logic b_wr_hi,
    input wire logic [dp_ram_pkg::DATA_W-1:0] b_wdata,
    output logic [dp_ram_pkg::DATA_W-1:0] b_rdata
);
    import dp_ram_pkg::*;

    // Only the two depths of the family are served
    if (ADDR_W != ADDR_W_4K && ADDR_W != ADDR_W_8K) begin : g_bad_width
        $error("ADDR_W must be 12 or 13");
    end

    typedef struct packed {
        logic [ADDR_W-1:0] cnt;
        logic rd_lo;
        logic rd_hi;
        logic pipe_rd_lo;
        logic pipe_rd_hi;
        logic [DATA_W-1:0] pipe_data;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] oe_n;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [ADDR_W-1:0] acc_addr;
    logic sel;
    logic wr_lo;
    logic wr_hi;
    logic [DATA_W-1:0] arr_rdata;
    logic [DATA_W-1:0] drive_mask;
    logic drv_lo;
    logic drv_hi;

    // Access address: zero when cleared, pins when strobed, counter plus one when advancing, counter otherwise
    always_comb begin
        if (!burst_clear_n) begin
            acc_addr = ADDR_W'(ADDR_ZERO);
        end else if (!addr_strobe_n) begin
            acc_addr = addr;
        end else if (!burst_advance_n) begin
            acc_addr = st_r.cnt + ADDR_W'(ADDR_ONE);
        end else begin
            acc_addr = st_r.cnt;
        end
    end

    assign sel = !port_sel_low_n && port_sel_high;
    assign wr_lo = sel && !rd_wr_n && !low_byte_sel_n;
    assign wr_hi = sel && !rd_wr_n && !high_byte_sel_n;

    // Array registers read data on the edge: this is the flow-through stage
    dp_ram_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .LOW_W(LOW_W)
    ) u_array (
        .clk(mclk),
        .addr_a(acc_addr),
        .wr_lo_a(wr_lo),
        .wr_hi_a(wr_hi),
        .wdata_a(data_in),
        .rdata_a(arr_rdata),
        .addr_b(b_addr),
        .wr_lo_b(b_wr_lo),
        .wr_hi_b(b_wr_hi),
        .wdata_b(b_wdata),
        .rdata_b(b_rdata)
    );

    // Lane drive chosen from the flow-through or pipelined stage
    always_comb begin
        if (output_register_sel) begin
            drv_lo = st_r.pipe_rd_lo;
            drv_hi = st_r.pipe_rd_hi;
        end else begin
            drv_lo = st_r.rd_lo;
            drv_hi = st_r.rd_hi;
        end
        drive_mask = {{(DATA_W-LOW_W){drv_hi}}, {LOW_W{drv_lo}}};
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = acc_addr;
        st_nxt.rd_lo = sel && rd_wr_n && !low_byte_sel_n;
        st_nxt.rd_hi = sel && rd_wr_n && !high_byte_sel_n;
        st_nxt.pipe_rd_lo = st_r.rd_lo;
        st_nxt.pipe_rd_hi = st_r.rd_hi;
        st_nxt.pipe_data = arr_rdata;
        // Output enable is sampled here each cycle; true async drive would
        // need a combinational output, which the house style forbids
        st_nxt.dout = output_register_sel ? st_r.pipe_data : arr_rdata;
        if (out_en_n) begin
            st_nxt.oe_n = {DATA_W{1'b1}};
        end else begin
            st_nxt.oe_n = ~drive_mask;
        end
        if (rst) begin
            st_nxt.cnt = ADDR_W'(ADDR_ZERO);
            st_nxt.rd_lo = 1'b0;
            st_nxt.rd_hi = 1'b0;
            st_nxt.pipe_rd_lo = 1'b0;
            st_nxt.pipe_rd_hi = 1'b0;
            st_nxt.pipe_data = DATA_ZERO;
            st_nxt.dout = DATA_ZERO;
            st_nxt.oe_n = {DATA_W{1'b1}};
        end
    end

    // Only clock edges move state, so a gated clock simply pauses the port
    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    assign data_out = st_r.dout;
    assign data_oe_n = st_r.oe_n;
endmodule
`default_nettype wire

// file: dp_ram_pkg.sv
// Shared constants for the synchronous dual-port RAM port
package dp_ram_pkg;
    localparam int DATA_W = 18;
    localparam int LOW_W = 9;
    localparam int ADDR_W_4K = 12;
    localparam int ADDR_W_8K = 13;
    localparam int ADDR_W_DEF = ADDR_W_8K;
    localparam logic [ADDR_W_DEF-1:0] ADDR_ZERO = 13'h0000;
    localparam logic [ADDR_W_DEF-1:0] ADDR_ONE = 13'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0_0000;
    localparam int PIPE_EXTRA_CYC = 1;
endpackage

// file: dp_ram_array.sv
// True dual-port word array with registered read data on each port
`timescale 1ns/100ps
`default_nettype none
module dp_ram_array #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 18,
    parameter int LOW_W = 9
) (
    // Clock shared by both ports
    input wire logic clk,
    // Port A
    input wire logic [ADDR_W-1:0] addr_a,
    input wire logic wr_lo_a,
    input wire logic wr_hi_a,
    input wire logic [DATA_W-1:0] wdata_a,
    output logic [DATA_W-1:0] rdata_a,
    // Port B
    input wire logic [ADDR_W-1:0] addr_b,
    input wire logic wr_lo_b,
    input wire logic wr_hi_b,
    input wire logic [DATA_W-1:0] wdata_b,
    output logic [DATA_W-1:0] rdata_b
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    if (LOW_W < 1 || LOW_W >= DATA_W) begin : g_bad_lanes
        $error("LOW_W must leave bits in both lanes");
    end

    // One process owns the array so it has a single driver; on a
    // same-word collision port B lands last, one of the undefined outcomes
    always_ff @(posedge clk) begin
        if (wr_lo_a) begin
            mem[addr_a][LOW_W-1:0] <= wdata_a[LOW_W-1:0];
        end
        if (wr_hi_a) begin
            mem[addr_a][DATA_W-1:LOW_W] <= wdata_a[DATA_W-1:LOW_W];
        end
        rdata_a <= mem[addr_a];
        if (wr_lo_b) begin
            mem[addr_b][LOW_W-1:0] <= wdata_b[LOW_W-1:0];
        end
        if (wr_hi_b) begin
            mem[addr_b][DATA_W-1:LOW_W] <= wdata_b[DATA_W-1:LOW_W];
        end
        rdata_b <= mem[addr_b];
    end
endmodule
`default_nettype wire

// file: dp_ram_port_assertions.sv
// Port-level checks of selects, byte lanes and read latency
`timescale 1ns/100ps
`default_nettype none
module dp_ram_port_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Controls
    input wire logic port_sel_low_n,
    input wire logic port_sel_high,
    input wire logic rd_wr_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    input wire logic out_en_n,
    input wire logic output_register_sel,
    // Lane enables
    input wire logic [dp_ram_pkg::DATA_W-1:0] data_oe_n
);
    import dp_ram_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic sel;
    logic rd;
    logic fl;
    logic both;
    assign sel = !port_sel_low_n && port_sel_high;
    assign rd = sel && rd_wr_n;
    assign fl = !output_register_sel;
    assign both = !low_byte_sel_n && !high_byte_sel_n;
    a_reset_undriven: assert property ($fell(rst) |-> data_oe_n == '1)
        else $error("Pins driven after reset");
    a_desel_undriven: assert property (
        fl && !sel ##1 fl |=> data_oe_n == '1)
        else $error("Deselected access drove pins");
    a_write_undriven: assert property (
        fl && sel && !rd_wr_n ##1 fl |=> data_oe_n == '1)
        else $error("Write drove pins");
    a_oe_off: assert property (out_en_n [*2] |=> data_oe_n == '1)
        else $error("Pins driven with output enable high");
    a_low_lane: assert property (
        fl && low_byte_sel_n ##1 fl |=> data_oe_n[LOW_W-1:0] == '1)
        else $error("Low lane driven while unselected");
    a_high_lane: assert property (
        fl && high_byte_sel_n ##1 fl |=> data_oe_n[DATA_W-1:LOW_W] == '1)
        else $error("High lane driven while unselected");
    a_read_flow: assert property (
        fl && rd && both && !out_en_n ##1 fl && !out_en_n
        |=> data_oe_n == '0) else $error("Flow read not driven");
    a_read_pipe: assert property (
        !fl && rd && both ##1 (!fl && !out_en_n) [*2]
        |=> data_oe_n == '0) else $error("Pipelined read not driven");
endmodule
bind dp_ram_port dp_ram_port_assertions dp_ram_port_assertions_inst (
    .mclk(mclk), .rst(rst), .port_sel_low_n(port_sel_low_n),
    .port_sel_high(port_sel_high), .rd_wr_n(rd_wr_n),
    .low_byte_sel_n(low_byte_sel_n), .high_byte_sel_n(high_byte_sel_n),
    .out_en_n(out_en_n), .output_register_sel(output_register_sel),
    .data_oe_n(data_oe_n));
`default_nettype wire

// file: second_port_user.sv
// Model of the user on the array's second port
`timescale 1ns/100ps
`default_nettype none
module second_port_user (
    // Clock
    input wire logic mclk,
    // Second port access
    output logic [12:0] b_addr,
    output logic b_wr_lo,
    output logic b_wr_hi,
    output logic [17:0] b_wdata,
    input wire logic [17:0] b_rdata
);
    initial begin
        {b_addr, b_wdata, b_wr_lo, b_wr_hi} = '0;
    end
    // Caller keeps port one off this word, so writes never collide
    task automatic put(input logic [12:0] a, input logic [17:0] d);
        @(negedge mclk);
        {b_addr, b_wdata, b_wr_lo, b_wr_hi} = {a, d, 2'h3};
        @(negedge mclk);
        {b_wr_lo, b_wr_hi, b_wdata} = {2'h0, ~d};
    endtask
    // Address taken at one edge, registered word read a half cycle later
    task automatic get(input logic [12:0] a, output logic [17:0] d);
        @(negedge mclk);
        b_addr = a;
        @(negedge mclk);
        d = b_rdata;
    endtask
endmodule
`default_nettype wire

// file: dp_ram_port_bench.sv
// Bench for one RAM port with a second-port user model
`timescale 1ns/100ps
`default_nettype none
module dp_ram_port_bench;
    logic mclk = 0, rst = 1, run = 1, lb = 0, ub = 0, oe = 0, md = 0;
    logic [5:0] ct = 6'h0f, rc = 6'h17;
    logic [12:0] a = 13'h0000, ba;
    logic [17:0] di = 18'h0_0000, q, qe, bw, br, g;
    logic bl, bh;
    int err_count = 0, checks = 0;
    always #4 if (run) mclk = ~mclk;
    dp_ram_port dp_ram_port_inst (.mclk(mclk), .rst(rst), .addr(a),
        .addr_strobe_n(ct[3]), .burst_advance_n(ct[2]),
        .burst_clear_n(ct[1]), .port_sel_low_n(ct[5]),
        .port_sel_high(ct[4]), .rd_wr_n(ct[0]), .low_byte_sel_n(lb),
        .high_byte_sel_n(ub), .out_en_n(oe), .output_register_sel(md),
        .data_in(di), .data_out(q), .data_oe_n(qe), .b_addr(ba),
        .b_wr_lo(bl), .b_wr_hi(bh), .b_wdata(bw), .b_rdata(br));
    second_port_user second_port_user_inst (.mclk(mclk), .b_addr(ba),
        .b_wr_lo(bl), .b_wr_hi(bh), .b_wdata(bw), .b_rdata(br));
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    // Control bits: sel_low_n, sel_high, strobe_n, advance_n, clear_n, rd_wr_n
    task automatic drv(input logic [5:0] c, input logic [12:0] ad,
        input logic [17:0] d);
        @(negedge mclk);
        {ct, a, di} = {c, ad, d};
    endtask
    task automatic rd(input logic [12:0] ad, input logic [17:0] e);
        logic [17:0] m;
        m = {{9{ub | oe}}, {9{lb | oe}}};
        drv(rc, ad, ~e);
        drv(6'h0f, ad, e);
        @(negedge mclk);
        if (md) begin
            chk(qe, 18'h3_ffff);
            @(negedge mclk);
        end
        chk(qe, m);
        chk(q & ~m, e & ~m);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst = 0;
        drv(6'h16, 13'h1fff, 18'h1_2345);
        drv(6'h1a, 13'h0000, 18'h2_aaaa);
        drv(6'h1a, 13'h0000, 18'h3_0f0f);
        drv(6'h10, 13'h0055, 18'h0_1357);
        drv(6'h12, 13'h0100, 18'h2_4680);
        drv(6'h36, 13'h0100, 18'h3_ffff);
        drv(6'h06, 13'h0100, 18'h3_ffff);
        rd(13'h1fff, 18'h1_2345);
        rd(13'h0000, 18'h0_1357);
        rd(13'h0001, 18'h3_0f0f);
        rd(13'h0100, 18'h2_4680);
        lb = 1;
        drv(6'h16, 13'h0100, 18'h3_ffff);
        rd(13'h0100, 18'h3_fe80);
        lb = 0;
        ub = 1;
        rd(13'h0100, 18'h3_fe80);
        ub = 0;
        oe = 1;
        rd(13'h0100, 18'h3_fe80);
        oe = 0;
        second_port_user_inst.put(13'h0a0a, 18'h1_5a5a);
        rd(13'h0a0a, 18'h1_5a5a);
        second_port_user_inst.get(13'h1fff, g);
        chk(g, 18'h1_2345);
        // Stopped clock must leave all state untouched
        run = 0;
        #82 run = 1;
        // Counter address, not the pins, after the pause
        rc = 6'h1f;
        rd(13'h0001, 18'h1_5a5a);
        rc = 6'h17;
        md = 1;
        rd(13'h1fff, 18'h1_2345);
        end_sim();
    end
endmodule
`default_nettype wire
